// file: inc/sipp_regs.svh
// register offsets, field positions and reset values of the parallel port
// assumes inclusion by bare name from the design files
`ifndef SIPP_REGS_SVH
`define SIPP_REGS_SVH
`define SIPP_OFS_PORT_A   2'h0
`define SIPP_OFS_PORT_B   2'h1
`define SIPP_OFS_PORT_C   2'h2
`define SIPP_OFS_CFG      2'h3
`define SIPP_CFG_FLAG     7
`define SIPP_CFG_A_MODE1  6
`define SIPP_CFG_A_MODE0  5
`define SIPP_CFG_A_IN     4
`define SIPP_CFG_CU_IN    3
`define SIPP_CFG_B_MODE   2
`define SIPP_CFG_B_IN     1
`define SIPP_CFG_CL_IN    0
`define SIPP_SR_SEL_HI    3
`define SIPP_SR_SEL_LO    1
`define SIPP_SR_VAL       0
`define SIPP_PC_IBF_A     5
`define SIPP_PC_STB_A     4
`define SIPP_PC_INTR_A    3
`define SIPP_PC_STB_B     2
`define SIPP_PC_IBF_B     1
`define SIPP_PC_INTR_B    0
`define SIPP_SEL_STB_A    3'h4
`define SIPP_SEL_STB_B    3'h2
`define SIPP_CFG_RST      8'h9b
`define SIPP_LAT_RST      8'h00
`define SIPP_CFG_A_STRB   8'hb0
`define SIPP_CFG_B_STRB   8'h86
`define SIPP_CFG_ALL_OUT  8'h80
`define SIPP_CFG_A_INPUT  8'h90
`define SIPP_CFG_B_INPUT  8'h82
`define SIPP_CFG_C_INPUT  8'h89
`endif

// file: inc/sipp_pkg.sv
// types shared by the parallel port design files
// assumes nothing of its surroundings
package sipp_pkg;
   typedef enum logic [1:0] {SIPP_BASIC, SIPP_STROBED, SIPP_BIDIR} sipp_mode_e;
   typedef struct packed {
      sipp_mode_e mode_a;
      logic       a_in;
      logic       cu_in;
      sipp_mode_e mode_b;
      logic       b_in;
      logic       cl_in;
      logic [7:0] a_lat;
      logic [7:0] b_lat;
      logic [7:0] c_lat;
      logic       inte_a;
      logic       inte_b;
      logic       stb_a_d;
      logic       stb_b_d;
      logic [7:0] pa_drv;
      logic [7:0] pa_drv_en;
      logic [7:0] pb_drv;
      logic [7:0] pb_drv_en;
      logic [7:0] pc_drv;
      logic [7:0] pc_drv_en;
      logic [7:0] rdata;
      logic       rvalid;
   } sipp_core_s;
endpackage

// file: logic/sipp_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output level is a register
`timescale 1ns/1ps
`default_nettype none
module sipp_sync
   import sipp_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] lvl
);
   generate
      if (WIDTH < 1) begin : g_chk
         $error("sipp_sync width must be at least one");
      end
   endgenerate

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } sipp_sync_s;

   sipp_sync_s st_r;
   sipp_sync_s st_nxt;

   // a bit changes once the second and third stage agree
   always_comb begin
      st_nxt     = st_r;
      st_nxt.s1  = pin;
      st_nxt.s2  = st_r.s1;
      st_nxt.s3  = st_r.s2;
      st_nxt.lvl = ((st_r.s2 ~^ st_r.s3) & st_r.s2)
                 | ((st_r.s2 ^ st_r.s3) & st_r.lvl);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lvl = st_r.lvl;
endmodule
`default_nettype wire

// file: logic/sipp_fifo.sv
// small flip-flop fifo with valid/ready on both sides and flush
// assumes one clock; out_data shows the head whenever out_valid
`timescale 1ns/1ps
`default_nettype none
module sipp_fifo
   import sipp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
         $error("sipp_fifo depth must be a power of two of at least two");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } sipp_fifo_s;

   sipp_fifo_s st_r;
   sipp_fifo_s st_nxt;
   logic       push;
   logic       pop;

   assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data  = st_r.mem[st_r.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_ready & out_valid;

   always_comb begin
      st_nxt = st_r;
      if (flush) begin
         st_nxt.wp  = '0;
         st_nxt.rp  = '0;
         st_nxt.cnt = '0;
      end else begin
         if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp           = st_r.wp + 1'b1;
         end
         if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
         end
         if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
         end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

// file: logic/sipp_port.sv
// 24-line parallel port: basic i/o and strobed input on ports a and b
// assumes a same-clock host issuing one-cycle read and write pulses;
// port pins are asynchronous and pass the synchroniser
//
// Function
// - strobed mode: two groups, port plus nibble
// - strobed data ports are latched
// - port c bits 6, 7 stay free
// - config 0xb0 selects port a strobed input
// - config 0x86 selects port b strobed input
// - port c bit 5 shows port a full
// - port c bit 1 shows port b full
// - bit 4 is a enable, set/reset only
// - bit 2 is b enable, set/reset only
// - bit 3 requests when a enabled and full
// - strobed pin map of port c
// - port c read shows enables, not strobes
// - config 0x80: all three ports output
// - config 0x90: a input, b c output
// - config 0x82: b input, a c output
// - config 0x89: c input, a b output
// - config bit 7 picks mode or set/reset
// - set/reset: bits 3..1 select, bit 0 value
// - basic mode: outputs latched, inputs direct
`timescale 1ns/1ps
`default_nettype none
`include "sipp_regs.svh"
module sipp_port
   import sipp_pkg::*;
#(
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [1:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   output logic      [7:0] bus_rdata,
   output logic            bus_rvalid,
   input  wire logic [7:0] pa_pin,
   output logic      [7:0] pa_drv,
   output logic      [7:0] pa_drv_en,
   input  wire logic [7:0] pb_pin,
   output logic      [7:0] pb_drv,
   output logic      [7:0] pb_drv_en,
   input  wire logic [7:0] pc_pin,
   output logic      [7:0] pc_drv,
   output logic      [7:0] pc_drv_en
);
   generate
      if (FIFO_DEPTH < 2) begin : g_chk
         $error("sipp_port needs a fifo depth of at least two");
      end
   endgenerate

   // apply a mode-select configuration byte; clears latches and enables
   function automatic sipp_core_s cfg_apply(sipp_core_s s, logic [7:0] w);
      sipp_core_s r;
      r = s;
      if (w[`SIPP_CFG_A_MODE1]) begin
         r.mode_a = SIPP_BIDIR;
      end else if (w[`SIPP_CFG_A_MODE0]) begin
         r.mode_a = SIPP_STROBED;
      end else begin
         r.mode_a = SIPP_BASIC;
      end
      r.mode_b = w[`SIPP_CFG_B_MODE] ? SIPP_STROBED : SIPP_BASIC;
      r.a_in   = w[`SIPP_CFG_A_IN];
      r.cu_in  = w[`SIPP_CFG_CU_IN];
      r.b_in   = w[`SIPP_CFG_B_IN];
      r.cl_in  = w[`SIPP_CFG_CL_IN];
      r.a_lat  = `SIPP_LAT_RST;
      r.b_lat  = `SIPP_LAT_RST;
      r.c_lat  = `SIPP_LAT_RST;
      r.inte_a = 1'b0;
      r.inte_b = 1'b0;
      return r;
   endfunction

   // read back a port: driven bits from the latch, others from the pin
   function automatic logic [7:0] port_rd(logic [7:0] en, logic [7:0] lat,
                                          logic [7:0] pin);
      return (en & lat) | (~en & pin);
   endfunction

   function automatic sipp_core_s core_reset();
      sipp_core_s r;
      r         = '0;
      r.stb_a_d = 1'b1;
      r.stb_b_d = 1'b1;
      return cfg_apply(r, `SIPP_CFG_RST);
   endfunction

   localparam sipp_core_s CORE_RST = core_reset();

   sipp_core_s st_r;
   sipp_core_s nx;
   logic [7:0] pa_lvl;
   logic [7:0] pb_lvl;
   logic [7:0] pc_lvl;
   logic       strb_a_in;
   logic       strb_b_in;
   logic       cfg_wr;
   logic       push_a;
   logic       push_b;
   logic       pop_a;
   logic       pop_b;
   logic       a_rdy;
   logic       b_rdy;
   logic       a_full;
   logic       b_full;
   logic [7:0] a_head;
   logic [7:0] b_head;
   logic [7:0] pc_en;
   logic [7:0] pc_val;
   logic [7:0] pc_rd;

   sipp_sync #(.WIDTH(8)) u_sync_a (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (pa_pin),
      .lvl     (pa_lvl)
   );

   sipp_sync #(.WIDTH(8)) u_sync_b (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (pb_pin),
      .lvl     (pb_lvl)
   );

   sipp_sync #(.WIDTH(8)) u_sync_c (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (pc_pin),
      .lvl     (pc_lvl)
   );

   // strobed input latches; a full fifo refuses further strobes
   sipp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo_a (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .flush     (cfg_wr),
      .in_valid  (push_a),
      .in_ready  (a_rdy),
      .in_data   (pa_lvl),
      .out_valid (a_full),
      .out_ready (pop_a),
      .out_data  (a_head)
   );

   sipp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo_b (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .flush     (cfg_wr),
      .in_valid  (push_b),
      .in_ready  (b_rdy),
      .in_data   (pb_lvl),
      .out_valid (b_full),
      .out_ready (pop_b),
      .out_data  (b_head)
   );

   assign strb_a_in = (st_r.mode_a == SIPP_STROBED) && st_r.a_in;
   assign strb_b_in = (st_r.mode_b == SIPP_STROBED) && st_r.b_in;
   assign cfg_wr    = bus_wr && (bus_addr == `SIPP_OFS_CFG)
                    && bus_wdata[`SIPP_CFG_FLAG];

   // port c direction and drive, nibble defaults then handshake lines
   always_comb begin
      pc_en  = {{4{~st_r.cu_in}}, {4{~st_r.cl_in}}};
      pc_val = st_r.c_lat;
      pc_rd  = port_rd(pc_en, st_r.c_lat, pc_lvl);
      if (strb_a_in) begin
         pc_en[`SIPP_PC_IBF_A]  = 1'b1;
         pc_en[`SIPP_PC_STB_A]  = 1'b0;
         pc_en[`SIPP_PC_INTR_A] = 1'b1;
         pc_val[`SIPP_PC_IBF_A]  = a_full;
         pc_val[`SIPP_PC_INTR_A] = st_r.inte_a & a_full;
         pc_rd[`SIPP_PC_IBF_A]   = a_full;
         pc_rd[`SIPP_PC_STB_A]   = st_r.inte_a;
         pc_rd[`SIPP_PC_INTR_A]  = st_r.inte_a & a_full;
      end
      if (strb_b_in) begin
         pc_en[`SIPP_PC_STB_B]  = 1'b0;
         pc_en[`SIPP_PC_IBF_B]  = 1'b1;
         pc_en[`SIPP_PC_INTR_B] = 1'b1;
         pc_val[`SIPP_PC_IBF_B]  = b_full;
         pc_val[`SIPP_PC_INTR_B] = st_r.inte_b & b_full;
         pc_rd[`SIPP_PC_STB_B]   = st_r.inte_b;
         pc_rd[`SIPP_PC_IBF_B]   = b_full;
         pc_rd[`SIPP_PC_INTR_B]  = st_r.inte_b & b_full;
      end
   end

   always_comb begin
      nx     = st_r;
      push_a = 1'b0;
      push_b = 1'b0;
      pop_a  = 1'b0;
      pop_b  = 1'b0;
      nx.stb_a_d = pc_lvl[`SIPP_PC_STB_A];
      nx.stb_b_d = pc_lvl[`SIPP_PC_STB_B];
      // falling strobe captures the pins while the fifo has room
      if (strb_a_in && st_r.stb_a_d && !pc_lvl[`SIPP_PC_STB_A]) begin
         push_a = a_rdy;
      end
      if (strb_b_in && st_r.stb_b_d && !pc_lvl[`SIPP_PC_STB_B]) begin
         push_b = b_rdy;
      end
      nx.rvalid = bus_rd;
      if (bus_rd) begin
         if (bus_addr == `SIPP_OFS_PORT_A) begin
            if (strb_a_in) begin
               nx.rdata = a_head;
               pop_a    = 1'b1;
            end else begin
               nx.rdata = port_rd(st_r.pa_drv_en, st_r.a_lat, pa_lvl);
            end
         end else if (bus_addr == `SIPP_OFS_PORT_B) begin
            if (strb_b_in) begin
               nx.rdata = b_head;
               pop_b    = 1'b1;
            end else begin
               nx.rdata = port_rd(st_r.pb_drv_en, st_r.b_lat, pb_lvl);
            end
         end else if (bus_addr == `SIPP_OFS_PORT_C) begin
            nx.rdata = pc_rd;
         end else begin
            nx.rdata = 8'h00;
         end
      end
      if (bus_wr) begin
         if (bus_addr == `SIPP_OFS_PORT_A) begin
            nx.a_lat = bus_wdata;
         end else if (bus_addr == `SIPP_OFS_PORT_B) begin
            nx.b_lat = bus_wdata;
         end else if (bus_addr == `SIPP_OFS_PORT_C) begin
            nx.c_lat = bus_wdata;
         end else if (cfg_wr) begin
            nx = cfg_apply(nx, bus_wdata);
         end else if (strb_a_in && bus_wdata[`SIPP_SR_SEL_HI:`SIPP_SR_SEL_LO]
                      == `SIPP_SEL_STB_A) begin
            nx.inte_a = bus_wdata[`SIPP_SR_VAL];
         end else if (strb_b_in && bus_wdata[`SIPP_SR_SEL_HI:`SIPP_SR_SEL_LO]
                      == `SIPP_SEL_STB_B) begin
            nx.inte_b = bus_wdata[`SIPP_SR_VAL];
         end else begin
            nx.c_lat[bus_wdata[`SIPP_SR_SEL_HI:`SIPP_SR_SEL_LO]] =
               bus_wdata[`SIPP_SR_VAL];
         end
      end
      // pins follow the latches and the direction bits
      nx.pa_drv    = st_r.a_lat;
      nx.pa_drv_en = st_r.a_in ? 8'h00 : 8'hff;
      nx.pb_drv    = st_r.b_lat;
      nx.pb_drv_en = st_r.b_in ? 8'h00 : 8'hff;
      nx.pc_drv    = pc_val;
      nx.pc_drv_en = pc_en;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= CORE_RST;
      end else begin
         st_r <= nx;
      end
   end

   assign bus_rdata  = st_r.rdata;
   assign bus_rvalid = st_r.rvalid;
   assign pa_drv     = st_r.pa_drv;
   assign pa_drv_en  = st_r.pa_drv_en;
   assign pb_drv     = st_r.pb_drv;
   assign pb_drv_en  = st_r.pb_drv_en;
   assign pc_drv     = st_r.pc_drv;
   assign pc_drv_en  = st_r.pc_drv_en;

   cfg_a_strobed_a: assert property (@(posedge sys_clk) disable iff (rst)
      bus_wr && bus_addr == `SIPP_OFS_CFG && bus_wdata == `SIPP_CFG_A_STRB
      |=> st_r.mode_a == SIPP_STROBED && st_r.a_in && !st_r.inte_a)
      else $error("config 0xb0 did not select port a strobed input");
   cfg_b_strobed_a: assert property (@(posedge sys_clk) disable iff (rst)
      bus_wr && bus_addr == `SIPP_OFS_CFG && bus_wdata[7]
      && bus_wdata[2] && bus_wdata[1]
      |=> st_r.mode_b == SIPP_STROBED && st_r.b_in)
      else $error("config with bits 7, 2, 1 set missed port b strobed");
   all_out_a: assert property (@(posedge sys_clk) disable iff (rst)
      bus_wr && bus_addr == `SIPP_OFS_CFG && bus_wdata == `SIPP_CFG_ALL_OUT
      ##1 !cfg_wr |=> pa_drv_en == 8'hff && pb_drv_en == 8'hff
      && pc_drv_en == 8'hff)
      else $error("config 0x80 did not drive all ports");
   a_input_a: assert property (@(posedge sys_clk) disable iff (rst)
      bus_wr && bus_addr == `SIPP_OFS_CFG && bus_wdata == `SIPP_CFG_A_INPUT
      ##1 !cfg_wr |=> pa_drv_en == 8'h00 && pb_drv_en == 8'hff
      && pc_drv_en == 8'hff)
      else $error("config 0x90 directions wrong");
   b_input_a: assert property (@(posedge sys_clk) disable iff (rst)
      bus_wr && bus_addr == `SIPP_OFS_CFG && bus_wdata == `SIPP_CFG_B_INPUT
      ##1 !cfg_wr |=> pa_drv_en == 8'hff && pb_drv_en == 8'h00
      && pc_drv_en == 8'hff)
      else $error("config 0x82 directions wrong");
   c_input_a: assert property (@(posedge sys_clk) disable iff (rst)
      bus_wr && bus_addr == `SIPP_OFS_CFG && bus_wdata == `SIPP_CFG_C_INPUT
      ##1 !cfg_wr |=> pa_drv_en == 8'hff && pb_drv_en == 8'hff
      && pc_drv_en == 8'h00)
      else $error("config 0x89 directions wrong");
   full_pins_a: assert property (@(posedge sys_clk) disable iff (rst)
      strb_a_in |=> pc_drv_en[5] && pc_drv[5] == $past(a_full))
      else $error("port c bit 5 does not show port a full");
   full_b_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
      strb_b_in |=> pc_drv_en[1] && pc_drv[1] == $past(b_full))
      else $error("port c bit 1 does not show port b full");
   irq_a_a: assert property (@(posedge sys_clk) disable iff (rst)
      strb_a_in |=> pc_drv[3] == $past(st_r.inte_a && a_full))
      else $error("port a request wrong");
   irq_b_a: assert property (@(posedge sys_clk) disable iff (rst)
      strb_b_in |=> pc_drv[0] == $past(st_r.inte_b && b_full))
      else $error("port b request wrong");
   inte_setreset_a: assert property (@(posedge sys_clk) disable iff (rst)
      strb_a_in && bus_wr && bus_addr == `SIPP_OFS_CFG && !bus_wdata[7]
      && bus_wdata[3:1] == 3'h4 |=> st_r.inte_a == $past(bus_wdata[0]))
      else $error("set/reset of bit 4 missed port a enable");
   rd_c_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
      bus_rd && bus_addr == `SIPP_OFS_PORT_C && strb_a_in
      |=> bus_rvalid && bus_rdata[4] == $past(st_r.inte_a))
      else $error("port c read bit 4 is not the port a enable");
   capture_a: assert property (@(posedge sys_clk) disable iff (rst)
      push_a && !cfg_wr |=> a_full ##1 pc_drv[5])
      else $error("strobe did not set port a full");
   free_bits_a: assert property (@(posedge sys_clk) disable iff (rst)
      strb_a_in && !st_r.cu_in
      |=> pc_drv_en[7:6] == 2'b11 && pc_drv[7:6] == $past(st_r.c_lat[7:6]))
      else $error("port c bits 6, 7 not free in strobed mode");
endmodule
`default_nettype wire

// file: test/sipp_periph.sv
// peripheral model: strobes bytes into one port group
// assumes the bench calls send; released data shows the inverted byte
`timescale 1ns/1ps
`default_nettype none
module sipp_periph (
   input  wire logic       sys_clk,
   output logic      [7:0] data,
   output logic            strobe_n
);
   initial begin
      data = 8'h00;
      strobe_n = 1'b1;
   end
   task automatic put(input logic [7:0] b);
      @(posedge sys_clk) data <= b;
   endtask
   // data stable five cycles around the low strobe, then released
   task automatic send(input logic [7:0] b, input int gap);
      put(b);
      repeat (5) @(posedge sys_clk);
      strobe_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      strobe_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      data <= ~b;
      repeat (gap) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// file: test/test_strobed_input_parallel_port.sv
// self-checking bench for the strobed input parallel port
// assumes peripheral models on ports a and b and a same-clock host
`timescale 1ns/1ps
`default_nettype none
`include "sipp_regs.svh"
`define CHK(g, e) check(g, e)
module test_strobed_input_parallel_port
   import sipp_pkg::*;
;
   logic       sys_clk, rst, bus_wr, bus_rd, bus_rvalid, stb_a_n, stb_b_n;
   logic [1:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, pa_drv, pa_drv_en, pb_drv, pb_drv_en;
   logic [7:0] pc_drv, pc_drv_en, pa_ext, pb_ext, pc_ext, rd_v;
   logic [7:0] pa_pin, pb_pin, pc_pin;
   int         miscompares, comparisons;

   assign pa_pin = (pa_drv & pa_drv_en) | (pa_ext & ~pa_drv_en);
   assign pb_pin = (pb_drv & pb_drv_en) | (pb_ext & ~pb_drv_en);
   assign pc_pin = (pc_drv & pc_drv_en) | ({pc_ext[7:5], stb_a_n,
                   pc_ext[3], stb_b_n, pc_ext[1:0]} & ~pc_drv_en);

   sipp_port #(.FIFO_DEPTH(4)) u_dut (.sys_clk, .rst, .bus_addr,
      .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .bus_rvalid, .pa_pin,
      .pa_drv, .pa_drv_en, .pb_pin, .pb_drv, .pb_drv_en, .pc_pin,
      .pc_drv, .pc_drv_en);
   sipp_periph u_pa (.sys_clk(sys_clk), .data(pa_ext), .strobe_n(stb_a_n));
   sipp_periph u_pb (.sys_clk(sys_clk), .data(pb_ext), .strobe_n(stb_b_n));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a);
      @(posedge sys_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      `CHK(bus_rvalid, 1'b1);
      rd_v = bus_rdata;
   endtask

   task automatic poll(input int n);
      for (int i = 0; i < 50; i++) begin
         rd(`SIPP_OFS_PORT_C);
         if (rd_v[n] === 1'b1) break;
      end
      `CHK(rd_v[n], 1'b1);
   endtask

   function automatic logic [7:0] en_of(input logic [7:0] c, input int p);
      case (p)
         0: en_of = c[4] ? 8'h00 : 8'hff;
         1: en_of = c[1] ? 8'h00 : 8'hff;
         default: en_of = {c[3] ? 4'h0 : 4'hf, c[0] ? 4'h0 : 4'hf};
      endcase
   endfunction

   task automatic basic(input logic [7:0] c);
      logic [7:0] w [3];
      logic [7:0] x [3];
      logic [7:0] e;
      wr(`SIPP_OFS_CFG, c);
      for (int p = 0; p < 3; p++) begin
         w[p] = 8'($urandom);
         wr(2'(p), w[p]);
      end
      x[0] = 8'($urandom);
      x[1] = 8'($urandom);
      x[2] = 8'($urandom) | 8'h14;
      u_pa.put(x[0]);
      u_pb.put(x[1]);
      pc_ext <= x[2];
      repeat (6) @(posedge sys_clk);
      for (int p = 0; p < 3; p++) begin
         e = en_of(c, p);
         rd(2'(p));
         `CHK(rd_v, (w[p] & e) | (x[p] & ~e));
      end
      `CHK(pa_drv_en, en_of(c, 0));
      `CHK(pb_drv_en, en_of(c, 1));
      `CHK(pc_drv_en, en_of(c, 2));
      `CHK(pa_drv & en_of(c, 0), w[0] & en_of(c, 0));
      `CHK(pb_drv & en_of(c, 1), w[1] & en_of(c, 1));
      `CHK(pc_drv & en_of(c, 2), w[2] & en_of(c, 2));
      $display("test basic %h done", c);
   endtask

   task automatic strobed(input bit g);
      logic [7:0] b [5];
      int         full, irq, en;
      logic [7:0] m;
      full = g ? 1 : 5;
      irq = g ? 0 : 3;
      en = g ? 2 : 4;
      m = g ? 8'h07 : 8'h38;
      wr(`SIPP_OFS_CFG, g ? `SIPP_CFG_B_STRB : `SIPP_CFG_A_STRB);
      wr(`SIPP_OFS_CFG, 8'(en * 2 + 1));
      if (!g) wr(`SIPP_OFS_PORT_C, 8'hc0);
      repeat (3) @(posedge sys_clk);
      `CHK(pc_drv_en[full], 1'b1);
      `CHK(pc_drv_en[irq], 1'b1);
      `CHK(pc_drv_en[en], 1'b0);
      if (!g) `CHK(pc_drv[7:6], 2'b11);
      for (int i = 0; i < 5; i++) begin
         b[i] = 8'($urandom);
         if (g) u_pb.send(b[i], i * 4);
         else u_pa.send(b[i], i * 4);
      end
      repeat (8) @(posedge sys_clk);
      `CHK(pc_drv[full], 1'b1);
      `CHK(pc_drv[irq], 1'b1);
      poll(full);
      `CHK(rd_v & m, m);
      wr(`SIPP_OFS_CFG, 8'(en * 2));
      repeat (3) @(posedge sys_clk);
      `CHK(pc_drv[irq], 1'b0);
      for (int i = 0; i < 4; i++) begin
         poll(full);
         rd(g ? `SIPP_OFS_PORT_B : `SIPP_OFS_PORT_A);
         `CHK(rd_v, b[i]);
      end
      repeat (3) @(posedge sys_clk);
      `CHK(pc_drv[full], 1'b0);
      rd(`SIPP_OFS_PORT_C);
      `CHK(rd_v & m, 8'h00);
      $display("test strobed group %0d done", g);
   endtask

   initial begin
      #200000;
      miscompares++;
      results();
   end

   initial begin
      rst = 1'b1;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 2'h0;
      bus_wdata = 8'h00;
      pc_ext = 8'h00;
      miscompares = 0;
      comparisons = 0;
      void'($urandom(59003));
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      basic(`SIPP_CFG_ALL_OUT);
      basic(`SIPP_CFG_A_INPUT);
      basic(`SIPP_CFG_B_INPUT);
      basic(`SIPP_CFG_C_INPUT);
      // bidirectional select falls back to basic i/o
      basic(8'hd9);
      for (int i = 0; i < 6; i++) basic(8'h80 | 8'($urandom & 8'h1b));
      wr(`SIPP_OFS_CFG, `SIPP_CFG_ALL_OUT);
      wr(`SIPP_OFS_CFG, 8'h0b);
      wr(`SIPP_OFS_CFG, 8'h0f);
      repeat (3) @(posedge sys_clk);
      `CHK(pc_drv, 8'ha0);
      strobed(1'b0);
      strobed(1'b1);
      results();
   end
endmodule
`default_nettype wire
